// ===== rtl/mpcs_pkg.sv
package mpcs_pkg;

    // ==========================================================================
    // Register byte offsets
    // ==========================================================================
    localparam logic [7:0] OFS_SYSCLK_SET = 8'h00;
    localparam logic [7:0] OFS_SYSCLK_CLR = 8'h04;
    localparam logic [7:0] OFS_SYSCLK_STATE = 8'h08;
    localparam logic [7:0] OFS_MAIN_FREQ = 8'h24;
    localparam logic [7:0] OFS_MAIN_PLL = 8'h28;
    localparam logic [7:0] OFS_MASTER_CLOCK = 8'h30;
    localparam logic [7:0] OFS_USB_CLOCK = 8'h38;
    localparam logic [7:0] OFS_PROGCLK0 = 8'h40;
    localparam logic [7:0] OFS_PROGCLK1 = 8'h44;
    localparam logic [7:0] OFS_IRQ_SET = 8'h60;
    localparam logic [7:0] OFS_IRQ_CLR = 8'h64;
    localparam logic [7:0] OFS_CLOCK_STATUS = 8'h68;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h6C;
    localparam logic [7:0] OFS_PUMP_CURRENT = 8'h80;
    localparam logic [7:0] OFS_PROTECT_MODE = 8'hE4;
    localparam logic [7:0] OFS_PROTECT_STATUS = 8'hE8;

    // ==========================================================================
    // Field positions and write masks
    // ==========================================================================
    localparam int MCK_SRC_LSB = 0;
    localparam int MCK_SCALE_LSB = 4;
    localparam int MCK_DIV_LSB = 8;
    localparam int MCK_HALF_BIT = 12;
    localparam logic [31:0] MCK_WRITE_MASK = 32'h0000_1373;
    localparam int PCK_SRC_LSB = 0;
    localparam int PCK_SCALE_LSB = 4;
    localparam logic [31:0] PCK_WRITE_MASK = 32'h0000_0077;
    localparam int SYSCLK_PCK_LSB = 8;
    localparam int SR_MAIN_LOCK_BIT = 1;
    localparam int SR_MASTER_READY_BIT = 3;
    localparam int SR_USB_LOCK_BIT = 6;
    localparam int SR_PROG_READY_LSB = 8;
    localparam logic [31:0] SR_IRQ_MASK = 32'h0000_034A;
    localparam int PROT_ENABLE_BIT = 0;
    localparam int PROT_VIOLATION_BIT = 0;
    localparam int PROT_SOURCE_LSB = 8;

    // ==========================================================================
    // Reset values
    // ==========================================================================
    localparam logic [31:0] MCK_RESET = 32'h0000_0001;
    localparam logic [31:0] PCK_RESET = 32'h0000_0000;
    localparam logic [31:0] MAIN_PLL_RESET = 32'h0000_3F00;
    localparam logic [31:0] PUMP_RESET = 32'h0100_0100;
    localparam logic [31:0] ZERO_RESET = 32'h0000_0000;

    // ==========================================================================
    // Clock source codes and switch timing, in edges of the new source
    // ==========================================================================
    localparam logic [2:0] SRC_SLOW = 3'h0;
    localparam logic [2:0] SRC_MAIN = 3'h1;
    localparam logic [2:0] SRC_MAIN_PLL = 3'h2;
    localparam logic [2:0] SRC_USB_PLL = 3'h3;
    localparam logic [2:0] SRC_MASTER = 3'h4;
    localparam logic [2:0] HSIZE_WORD = 3'h2;
    localparam logic [6:0] SWITCH_EDGES = 7'h04;
    localparam logic [6:0] SCALE_EXTRA_EDGES = 7'h40;

endpackage

// ===== rtl/mpcs_top.sv
// Our own choices: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// (R1) Master source selector picks the divider source; resets to main clock.
// (R2) Prescaler divides selected master source by 1, 2, 4, 8, 16, 32 or 64.
// (R3) Master divider code 0..3 divides processor clock by 1..4 for master clock.
// (R4) Half-divide bit halves the main PLL clock before master selection.
// (R5) Master divider and half-divide reset to zero.
// (R6) After a master register write, ready flag sets once the clock settles.
// (R7) Software going to a PLL writes prescaler first, then the source.
// (R8) Software going to main or slow writes the source first, then prescaler.
// (R9) Source or prescaler change drops ready until the clocks are stable.
// (R10) Ready stays low while the selected PLL is unlocked, sets on relock.
// (R11) While the selected PLL is unlocked the master runs from slow clock.
// (R12) Two output clocks, set and clear writes, state readable, off at reset.
// (R13) Output clock source: main, slow, master, main PLL, USB PLL; slow default.
// (R14) Output clock prescaler 1..64, resets to divide by one.
// (R15) Output clock ready flag sets after enabling; single-write configuration.
// (R16) Software disables an output clock before changing its parameters.
// (R17) Software touches peripheral clocks only after clock setup completes.
// (R18) Active prescaler adds 64 new-source edges to the master switch time.
// (R19) Protect enable bit blocks writes to clock registers.
// (R20) A blocked write sets the violation flag and records the target offset.
// (R21) Reading the protect status register clears the violation flag.
// (R22) Protected set: sysclk set/clear, frequency, PLL, master, USB, output, pump.
// (R23) A blocked write leaves the target register unchanged.
module mpcs_top (
    input wire logic i_clk, // System clock, 50 MHz.
    input wire logic i_rst_n, // Synchronous reset, active low.
    input wire logic i_hsel, // AHB slave select.
    input wire logic [31:0] i_haddr, // AHB address.
    input wire logic [1:0] i_htrans, // AHB transfer type.
    input wire logic i_hwrite, // AHB write strobe.
    input wire logic [2:0] i_hsize, // AHB transfer size.
    input wire logic [31:0] i_hwdata, // AHB write data.
    input wire logic i_hready, // AHB bus ready.
    output logic o_hreadyout, // AHB slave ready.
    output logic o_hresp, // AHB response, always OKAY.
    output logic [31:0] o_hrdata, // AHB read data.
    input wire logic i_slow_clock, // Slow clock level.
    input wire logic i_main_clock, // Main clock level.
    input wire logic i_main_pll_clock, // Main PLL clock level.
    input wire logic i_usb_pll_clock, // USB PLL clock level.
    input wire logic i_main_pll_lock_flag, // Main PLL locked.
    input wire logic i_usb_pll_lock_flag, // USB PLL locked.
    output logic o_proc_tick, // One pulse per processor clock period.
    output logic o_master_tick, // One pulse per master clock period.
    output logic [1:0] o_progclk_tick, // One pulse per output clock period.
    output logic [1:0] o_master_source, // Source the master path runs from.
    output logic [31:0] o_main_pll_config, // Main PLL configuration word.
    output logic o_irq // Clock status interrupt.
);

    // ==========================================================================
    // Functions
    // ==========================================================================
    function automatic logic [6:0] div_term(input logic [2:0] code);
        logic [2:0] p;
        p = (code > 3'h6) ? 3'h6 : code;
        div_term = 7'((8'h01 << p) - 8'h01);
    endfunction

    // ==========================================================================
    // Pin synchronisers and edge detection
    // ==========================================================================
    logic [5:0] sync1_reg;
    logic [5:0] sync2_reg;
    logic [5:0] prev_reg;
    logic half_tgl_reg;
    logic [3:0] rise;
    logic [3:0] src_edges;
    logic main_lock;
    logic usb_lock;

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            sync1_reg <= 6'h00;
            sync2_reg <= 6'h00;
            prev_reg <= 6'h00;
        end else begin
            sync1_reg <= {i_usb_pll_lock_flag, i_main_pll_lock_flag, i_usb_pll_clock,
                          i_main_pll_clock, i_main_clock, i_slow_clock};
            sync2_reg <= sync1_reg;
            prev_reg <= sync2_reg;
        end
    end

    assign rise = sync2_reg[3:0] & ~prev_reg[3:0];
    assign main_lock = sync2_reg[4];
    assign usb_lock = sync2_reg[5];

    // ==========================================================================
    // AHB-Lite slave: one wait cycle per data phase
    // ==========================================================================
    logic wait_reg;
    logic pw_reg;
    logic pok_reg;
    logic [7:0] pa_reg;
    logic acc;

    assign acc = i_hsel & i_htrans[1] & i_hready;

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            wait_reg <= 1'b0;
            pw_reg <= 1'b0;
            pok_reg <= 1'b0;
            pa_reg <= 8'h00;
        end else begin
            wait_reg <= acc;
            if (acc) begin
                pw_reg <= i_hwrite;
                pa_reg <= i_haddr[7:0];
                pok_reg <= (i_hsize == mpcs_pkg::HSIZE_WORD) && (i_haddr[1:0] == 2'h0);
            end
        end
    end

    assign o_hreadyout = ~wait_reg;
    assign o_hresp = 1'b0;

    wire wr_go = wait_reg & pw_reg & pok_reg;
    wire rd_go = wait_reg & ~pw_reg;
    wire hit_set = (pa_reg == mpcs_pkg::OFS_SYSCLK_SET);
    wire hit_clr = (pa_reg == mpcs_pkg::OFS_SYSCLK_CLR);
    wire hit_state = (pa_reg == mpcs_pkg::OFS_SYSCLK_STATE);
    wire hit_freq = (pa_reg == mpcs_pkg::OFS_MAIN_FREQ);
    wire hit_pll = (pa_reg == mpcs_pkg::OFS_MAIN_PLL);
    wire hit_mck = (pa_reg == mpcs_pkg::OFS_MASTER_CLOCK);
    wire hit_usb = (pa_reg == mpcs_pkg::OFS_USB_CLOCK);
    wire hit_pck0 = (pa_reg == mpcs_pkg::OFS_PROGCLK0);
    wire hit_pck1 = (pa_reg == mpcs_pkg::OFS_PROGCLK1);
    wire hit_iset = (pa_reg == mpcs_pkg::OFS_IRQ_SET);
    wire hit_iclr = (pa_reg == mpcs_pkg::OFS_IRQ_CLR);
    wire hit_sr = (pa_reg == mpcs_pkg::OFS_CLOCK_STATUS);
    wire hit_imask = (pa_reg == mpcs_pkg::OFS_IRQ_MASK);
    wire hit_pump = (pa_reg == mpcs_pkg::OFS_PUMP_CURRENT);
    wire hit_pmode = (pa_reg == mpcs_pkg::OFS_PROTECT_MODE);
    wire hit_pstat = (pa_reg == mpcs_pkg::OFS_PROTECT_STATUS);

    // ==========================================================================
    // Write protection
    // ==========================================================================
    logic prot_en_reg;
    logic vio_reg;
    logic [7:0] vsrc_reg;

    wire hit_protected = hit_set | hit_clr | hit_freq | hit_pll | hit_mck | hit_usb
                         | hit_pck0 | hit_pck1 | hit_pump; // R22
    wire blocked = wr_go & prot_en_reg & hit_protected; // R19
    wire wr_ok = wr_go & ~blocked; // R23
    wire we_set = wr_ok & hit_set;
    wire we_clr = wr_ok & hit_clr;
    wire we_mck = wr_ok & hit_mck;
    wire [1:0] we_pck = {wr_ok & hit_pck1, wr_ok & hit_pck0};

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            prot_en_reg <= 1'b0;
            vio_reg <= 1'b0;
            vsrc_reg <= 8'h00;
        end else begin
            if (wr_ok && hit_pmode) begin
                prot_en_reg <= i_hwdata[mpcs_pkg::PROT_ENABLE_BIT];
            end
            if (blocked) begin
                vio_reg <= 1'b1; // R20
                vsrc_reg <= pa_reg; // R20
            end else if (rd_go && hit_pstat) begin
                vio_reg <= 1'b0; // R21
            end
        end
    end

    // ==========================================================================
    // Plain configuration words
    // ==========================================================================
    logic [31:0] freq_reg;
    logic [31:0] pll_reg;
    logic [31:0] usb_reg;
    logic [31:0] pump_reg;
    logic [31:0] irqm_reg;

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            freq_reg <= mpcs_pkg::ZERO_RESET;
            pll_reg <= mpcs_pkg::MAIN_PLL_RESET;
            usb_reg <= mpcs_pkg::ZERO_RESET;
            pump_reg <= mpcs_pkg::PUMP_RESET;
            irqm_reg <= mpcs_pkg::ZERO_RESET;
        end else begin
            if (wr_ok && hit_freq) begin
                freq_reg <= i_hwdata;
            end
            if (wr_ok && hit_pll) begin
                pll_reg <= i_hwdata;
            end
            if (wr_ok && hit_usb) begin
                usb_reg <= i_hwdata;
            end
            if (wr_ok && hit_pump) begin
                pump_reg <= i_hwdata;
            end
            if (wr_ok && hit_iset) begin
                irqm_reg <= (irqm_reg | i_hwdata) & mpcs_pkg::SR_IRQ_MASK;
            end else if (wr_ok && hit_iclr) begin
                irqm_reg <= irqm_reg & ~i_hwdata;
            end
        end
    end

    assign o_main_pll_config = pll_reg;

    // ==========================================================================
    // Master clock path
    // ==========================================================================
    logic [31:0] mck_reg;
    logic [6:0] mpres_cnt_reg;
    logic [1:0] mck_div_cnt_reg;
    logic [6:0] sw_cnt_reg;
    logic ready_reg;
    logic proc_tick_reg;
    logic master_tick_reg;

    wire [1:0] mck_src = mck_reg[mpcs_pkg::MCK_SRC_LSB +: 2];
    wire [2:0] mck_scale = mck_reg[mpcs_pkg::MCK_SCALE_LSB +: 3];
    wire [1:0] mck_div = mck_reg[mpcs_pkg::MCK_DIV_LSB +: 2];
    wire mck_half = mck_reg[mpcs_pkg::MCK_HALF_BIT];
    wire [6:0] mck_term = div_term(mck_scale);
    wire [2:0] new_scale = i_hwdata[mpcs_pkg::MCK_SCALE_LSB +: 3];

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            half_tgl_reg <= 1'b0;
        end else if (rise[2]) begin
            half_tgl_reg <= ~half_tgl_reg;
        end
    end

    assign src_edges = {rise[3], mck_half ? (rise[2] & half_tgl_reg) : rise[2], // R4
                        rise[1], rise[0]};

    wire sel_unlocked = ((3'(mck_src) == mpcs_pkg::SRC_MAIN_PLL) && !main_lock)
                        || ((3'(mck_src) == mpcs_pkg::SRC_USB_PLL) && !usb_lock);
    wire [1:0] eff_src = sel_unlocked ? mpcs_pkg::SRC_SLOW[1:0] : mck_src; // R11
    wire msrc_edge = src_edges[eff_src]; // R1
    wire proc_hit = msrc_edge & (mpres_cnt_reg >= mck_term); // R2
    wire master_hit = proc_hit & (mck_div_cnt_reg >= mck_div); // R3

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            mck_reg <= mpcs_pkg::MCK_RESET; // R1 R5
            mpres_cnt_reg <= 7'h00;
            mck_div_cnt_reg <= 2'h0;
            proc_tick_reg <= 1'b0;
            master_tick_reg <= 1'b0;
        end else begin
            if (we_mck) begin
                mck_reg <= i_hwdata & mpcs_pkg::MCK_WRITE_MASK;
            end
            if (msrc_edge) begin
                mpres_cnt_reg <= proc_hit ? 7'h00 : mpres_cnt_reg + 7'h01;
            end
            if (proc_hit) begin
                mck_div_cnt_reg <= master_hit ? 2'h0 : mck_div_cnt_reg + 2'h1;
            end
            proc_tick_reg <= proc_hit;
            master_tick_reg <= master_hit;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            sw_cnt_reg <= 7'h00;
            ready_reg <= 1'b1;
        end else if (we_mck) begin
            ready_reg <= 1'b0; // R6 R9
            sw_cnt_reg <= (new_scale != 3'h0)
                          ? mpcs_pkg::SWITCH_EDGES + mpcs_pkg::SCALE_EXTRA_EDGES
                          : mpcs_pkg::SWITCH_EDGES; // R18
        end else begin
            if (msrc_edge && sw_cnt_reg != 7'h00) begin
                sw_cnt_reg <= sw_cnt_reg - 7'h01;
            end
            ready_reg <= (sw_cnt_reg == 7'h00) && !sel_unlocked; // R6 R10
        end
    end

    assign o_proc_tick = proc_tick_reg;
    assign o_master_tick = master_tick_reg;
    assign o_master_source = eff_src;

    // ==========================================================================
    // Programmable output clocks
    // ==========================================================================
    logic [31:0] pck_reg [2];
    logic [6:0] ppres_cnt_reg [2];
    logic [1:0] pck_en_reg;
    logic [1:0] prdy_reg;
    logic [1:0] ptick_reg;
    logic [1:0] pck_hit;

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            pck_en_reg <= 2'h0; // R12
        end else begin
            pck_en_reg <= (pck_en_reg | ({2{we_set}} & i_hwdata[mpcs_pkg::SYSCLK_PCK_LSB +: 2]))
                          & ~({2{we_clr}} & i_hwdata[mpcs_pkg::SYSCLK_PCK_LSB +: 2]); // R12
        end
    end

    for (genvar g = 0; g < 2; g++) begin : g_prog
        wire [2:0] p_src = pck_reg[g][mpcs_pkg::PCK_SRC_LSB +: 3];
        wire [6:0] p_term = div_term(pck_reg[g][mpcs_pkg::PCK_SCALE_LSB +: 3]);
        wire p_edge = (p_src == mpcs_pkg::SRC_MASTER) ? master_hit :
                      (p_src < mpcs_pkg::SRC_MASTER) ? src_edges[p_src[1:0]] : 1'b0; // R13
        assign pck_hit[g] = p_edge & (ppres_cnt_reg[g] >= p_term); // R14

        always_ff @(posedge i_clk) begin
            if (!i_rst_n) begin
                pck_reg[g] <= mpcs_pkg::PCK_RESET; // R13 R14
                ppres_cnt_reg[g] <= 7'h00;
                prdy_reg[g] <= 1'b0;
                ptick_reg[g] <= 1'b0;
            end else begin
                if (we_pck[g]) begin
                    pck_reg[g] <= i_hwdata & mpcs_pkg::PCK_WRITE_MASK; // R15
                end
                if (p_edge) begin
                    ppres_cnt_reg[g] <= pck_hit[g] ? 7'h00 : ppres_cnt_reg[g] + 7'h01;
                end
                if (pck_en_reg[g] && pck_hit[g]) begin
                    prdy_reg[g] <= 1'b1; // R15
                end else if (!pck_en_reg[g] || we_pck[g]) begin
                    prdy_reg[g] <= 1'b0;
                end
                ptick_reg[g] <= pck_hit[g] & pck_en_reg[g]; // R12
            end
        end
    end

    assign o_progclk_tick = ptick_reg;

    // ==========================================================================
    // Status, interrupt and read data
    // ==========================================================================
    logic [31:0] sr_val;
    logic [31:0] rd_mux;
    logic irq_reg;
    logic [31:0] hrdata_reg;

    always_comb begin
        sr_val = 32'h0000_0000;
        sr_val[mpcs_pkg::SR_MAIN_LOCK_BIT] = main_lock;
        sr_val[mpcs_pkg::SR_MASTER_READY_BIT] = ready_reg;
        sr_val[mpcs_pkg::SR_USB_LOCK_BIT] = usb_lock;
        sr_val[mpcs_pkg::SR_PROG_READY_LSB +: 2] = prdy_reg;
    end

    wire [31:0] state_val = {22'h000000, pck_en_reg, 8'h00};
    wire [31:0] pstat_val = {16'h0000, vsrc_reg, 7'h00, vio_reg};
    wire [31:0] pmode_val = {31'h00000000, prot_en_reg};

    assign rd_mux = hit_state ? state_val :
                    hit_freq ? freq_reg :
                    hit_pll ? pll_reg :
                    hit_mck ? mck_reg :
                    hit_usb ? usb_reg :
                    hit_pck0 ? pck_reg[0] :
                    hit_pck1 ? pck_reg[1] :
                    hit_sr ? sr_val :
                    hit_imask ? irqm_reg :
                    hit_pump ? pump_reg :
                    hit_pmode ? pmode_val :
                    hit_pstat ? pstat_val : 32'h0000_0000;

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            hrdata_reg <= 32'h0000_0000;
            irq_reg <= 1'b0;
        end else begin
            if (rd_go) begin
                hrdata_reg <= rd_mux;
            end
            irq_reg <= |(sr_val & irqm_reg); // R6 R15
        end
    end

    assign o_hrdata = hrdata_reg;
    assign o_irq = irq_reg;

endmodule // mpcs_top

`default_nettype wire

// ===== verif/mpcs_chk.sv
`timescale 1ns/1ps
`default_nettype none
// =============================================================================
// Port checker for the clock selection block.
module mpcs_chk (
    input wire logic i_clk, // Clock.
    input wire logic i_rst_n, // Reset, active low.
    input wire logic i_hsel, // Select.
    input wire logic [1:0] i_htrans, // Transfer type.
    input wire logic i_hready, // Bus ready.
    input wire logic o_hreadyout, // Slave ready.
    input wire logic o_hresp, // Response.
    input wire logic [31:0] o_hrdata, // Read data.
    input wire logic i_main_pll_lock_flag, // Main PLL lock.
    input wire logic i_usb_pll_lock_flag, // USB PLL lock.
    input wire logic o_proc_tick, // Processor tick.
    input wire logic [1:0] o_progclk_tick, // Output clock ticks.
    input wire logic [1:0] o_master_source // Effective source.
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    property p_reset;
        $rose(i_rst_n) |-> o_master_source == 2'h1 && !o_proc_tick && o_progclk_tick == 2'h0;
    endproperty
    property p_wait;
        i_hsel && i_htrans[1] && i_hready && o_hreadyout |=> !o_hreadyout ##1 o_hreadyout;
    endproperty
    property p_okay;
        o_hresp == 1'b0;
    endproperty
    property p_rdata;
        $changed(o_hrdata) |-> $past(o_hreadyout) == 1'b0;
    endproperty
    property p_mlock;
        !i_main_pll_lock_flag [*4] |-> o_master_source != 2'h2;
    endproperty
    property p_ulock;
        !i_usb_pll_lock_flag [*4] |-> o_master_source != 2'h3;
    endproperty
    property p_ptick;
        o_proc_tick |=> !o_proc_tick;
    endproperty
    property p_ctick;
        o_progclk_tick != 2'h0 |=> (o_progclk_tick & $past(o_progclk_tick)) == 2'h0;
    endproperty
    a_reset: assert property (p_reset) else $error("bad state after reset");
    a_wait: assert property (p_wait) else $error("wait state not one cycle");
    a_okay: assert property (p_okay) else $error("response not OKAY");
    a_rdata: assert property (p_rdata) else $error("read data moved outside a transfer");
    a_mlock: assert property (p_mlock) else $error("master on unlocked main PLL");
    a_ulock: assert property (p_ulock) else $error("master on unlocked USB PLL");
    a_ptick: assert property (p_ptick) else $error("processor tick too long");
    a_ctick: assert property (p_ctick) else $error("output clock tick too long");
    c_wait: cover property (i_hsel && i_htrans[1] && i_hready);
    c_pll: cover property (o_master_source == 2'h2);
    c_pck: cover property (o_progclk_tick[1]);
endmodule // mpcs_chk
bind mpcs_top mpcs_chk u_chk (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_hsel(i_hsel),
    .i_htrans(i_htrans), .i_hready(i_hready), .o_hreadyout(o_hreadyout), .o_hresp(o_hresp),
    .o_hrdata(o_hrdata), .i_main_pll_lock_flag(i_main_pll_lock_flag),
    .i_usb_pll_lock_flag(i_usb_pll_lock_flag), .o_proc_tick(o_proc_tick),
    .o_progclk_tick(o_progclk_tick), .o_master_source(o_master_source));
`default_nettype wire

// ===== verif/testbench.sv
`timescale 1ns/1ps
`default_nettype none
// =============================================================================
// Register level test of the clock selection block.
module testbench;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic mlock = 1'b1;
    logic ulock = 1'b1;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = mpcs_pkg::HSIZE_WORD;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [5:0] cnt = 6'h00;
    logic hreadyout, hresp, ptick, mtick, irq;
    logic [1:0] ctick, msrc;
    logic [31:0] hrdata, r, pllc;
    logic [3:0] ticks;
    int n_errors = 0;
    int n_compared = 0;
    int per [5] = '{64, 8, 16, 32, 8};
    logic [7:0] rof [8] = '{8'h30, 8'h68, 8'h40, 8'h44, 8'h08, 8'hE4, 8'hE8, 8'h0C};
    logic [7:0] prot [9] = '{8'h00, 8'h04, 8'h24, 8'h28, 8'h30, 8'h38, 8'h40, 8'h44, 8'h80};
    assign ticks = {ctick, mtick, ptick};
    initial begin
        forever #10 clk = ~clk;
    end
    // Source clocks of 64, 8, 16 and 32 system cycles.
    always @(posedge clk) cnt <= cnt + 6'h01;
    mpcs_top DUT (.i_clk(clk), .i_rst_n(rst_n), .i_hsel(hsel), .i_haddr(haddr),
        .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize), .i_hwdata(hwdata),
        .i_hready(hreadyout), .o_hreadyout(hreadyout), .o_hresp(hresp), .o_hrdata(hrdata),
        .i_slow_clock(cnt[5]), .i_main_clock(cnt[2]), .i_main_pll_clock(cnt[3]),
        .i_usb_pll_clock(cnt[4]), .i_main_pll_lock_flag(mlock), .i_usb_pll_lock_flag(ulock),
        .o_proc_tick(ptick), .o_master_tick(mtick), .o_progclk_tick(ctick),
        .o_master_source(msrc), .o_main_pll_config(pllc), .o_irq(irq));
    task automatic test_done;
        $display("Errors: %0d, compares: %0d", n_errors, n_compared);
        if (n_errors == 0 && n_compared > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic hold;
        int k;
        k = 0;
        do begin @(posedge clk); k++; end while (hreadyout !== 1'b1 && k < 50);
        if (hreadyout !== 1'b1) begin n_errors++; test_done; end
    endtask
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr <= {24'h000000, a};
        hold;
        htrans <= 2'h0;
        hwdata <= d;
        hold;
        r = hrdata;
    endtask
    task automatic flag(input logic [31:0] m);
        int k;
        k = 0;
        do begin bus(1'b0, 8'h68, 32'h0); k++; end while ((r & m) !== m && k < 1500);
        if ((r & m) !== m) begin n_errors++; test_done; end
    endtask
    task automatic mck(input logic [31:0] v);
        bus(1'b1, 8'h30, v);
        bus(1'b0, 8'h68, 32'h0);
        chk(r & 32'h8, 32'h0);
        flag(32'h8);
    endtask
    task automatic gap(input int sel, input int exp);
        int n;
        for (int j = 0; j < 3; j++) begin
            n = 0;
            do begin @(posedge clk); n++; end while (ticks[sel] !== 1'b1 && n < 3000);
        end
        chk(n, exp);
    endtask
    initial begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            bus(1'b0, rof[i], 32'h0);
            chk(r, i == 0 ? 32'h1 : (i == 1 ? 32'h4A : 32'h0));
        end
        bus(1'b1, 8'h60, 32'h8);
        bus(1'b0, 8'h6C, 32'h0);
        chk(r, 32'h8);
        chk(irq, 32'h1);
        bus(1'b1, 8'h64, 32'h8);
        bus(1'b0, 8'h6C, 32'h0);
        chk(irq, 32'h0);
        gap(0, 8);
        for (int p = 0; p < 7; p++) begin
            mck(32'h1 | (p << 4));
            gap(0, 8 << p);
        end
        bus(1'b1, 8'h30, 32'h11);
        repeat (100) @(posedge clk);
        bus(1'b0, 8'h68, 32'h0);
        chk(r & 32'h8, 32'h0);
        flag(32'h8);
        for (int m = 0; m < 4; m++) begin
            mck(32'h11 | (m << 8));
            gap(1, 16 * (m + 1));
        end
        mck(32'h12);
        chk(msrc, 32'h2);
        gap(0, 32);
        mck(32'h1012);
        gap(0, 64);
        mlock <= 1'b0;
        ulock <= 1'b0;
        repeat (8) @(posedge clk);
        chk(msrc, 32'h0);
        bus(1'b0, 8'h68, 32'h0);
        chk(r & 32'h4A, 32'h0);
        mlock <= 1'b1;
        ulock <= 1'b1;
        flag(32'h4A);
        chk(msrc, 32'h2);
        mck(32'h13);
        chk(msrc, 32'h3);
        gap(0, 64);
        mck(32'h11);
        mck(32'h01);
        chk(msrc, 32'h1);
        bus(1'b1, 8'h00, 32'h100);
        flag(32'h100);
        gap(2, 64);
        bus(1'b0, 8'h08, 32'h0);
        chk(r, 32'h100);
        for (int i = 0; i < 5; i++) begin
            bus(1'b1, 8'h04, 32'h200);
            bus(1'b1, 8'h44, 32'h10 | i);
            bus(1'b1, 8'h00, 32'h200);
            flag(32'h200);
            gap(3, per[i] * 2);
        end
        bus(1'b1, 8'h04, 32'h300);
        bus(1'b0, 8'h08, 32'h0);
        chk(r, 32'h0);
        bus(1'b0, 8'h68, 32'h0);
        chk(r & 32'h300, 32'h0);
        bus(1'b1, 8'hE4, 32'h1);
        for (int i = 0; i < 9; i++) begin
            bus(1'b1, prot[i], 32'h55);
            bus(1'b0, 8'hE8, 32'h0);
            chk(r, {16'h0000, prot[i], 8'h01});
            bus(1'b0, 8'hE8, 32'h0);
            chk(r & 32'h1, 32'h0);
        end
        chk(pllc, 32'h3F00);
        bus(1'b0, 8'h44, 32'h0);
        chk(r, 32'h14);
        bus(1'b1, 8'hE4, 32'h0);
        bus(1'b1, 8'h44, 32'h55);
        bus(1'b0, 8'h44, 32'h0);
        chk(r, 32'h55);
        bus(1'b1, 8'h10, 32'h1);
        bus(1'b0, 8'h10, 32'h0);
        chk(r, 32'h0);
        test_done;
    end
endmodule // testbench
`default_nettype wire
